// ---- design/isb_defines.vh ----
// Constants for the interrupt source and time base block
`ifndef ISB_DEFINES_VH
`define ISB_DEFINES_VH

// Register offsets
`define ISB_PSC0_OFS 8'h00
`define ISB_PSC1_OFS 8'h01
`define ISB_TIMEBASE0_CONTROL_OFS 8'h02
`define ISB_TIMEBASE1_CONTROL_OFS 8'h03
`define ISB_IEN_OFS 8'h04
`define ISB_GEN_OFS 8'h05
`define ISB_FLAG_OFS 8'h06
`define ISB_TM0_OFS 8'h07
`define ISB_TM1_OFS 8'h08
`define ISB_STAT_OFS 8'h09

// Control register fields
`define ISB_TB_RUN_BIT 7
`define ISB_SRC_SYS 2'h0
`define ISB_SRC_SYS4 2'h1
`define ISB_PERIOD_BASE 4'h8

// Enable register fields
`define ISB_GIE_BIT 0

// Timer register fields
`define ISB_TM_PE_BIT 0
`define ISB_TM_SE_BIT 1
`define ISB_TM_PF_BIT 4
`define ISB_TM_SF_BIT 5

// Vector numbers, lower number wins
`define ISB_VEC_SER 3'h0
`define ISB_VEC_TB0 3'h1
`define ISB_VEC_TB1 3'h2
`define ISB_VEC_EE 3'h3
`define ISB_VEC_ADC 3'h4
`define ISB_VEC_GRP0 3'h5
`define ISB_VEC_GRP1 3'h6
`define ISB_VEC_LV 3'h7

// Reset values and timing
`define ISB_REG_RST 8'h00
`define ISB_SYS_DIV 2'h3

`endif

// ---- design/isb_timebase.v ----
// One time base: prescaler source select and programmable divider
`timescale 1ns/100ps
module isb_timebase #(
	parameter CNT_W = 15
) (
	// Clock and reset
	input wire clock,
	input wire arst_n,
	input wire clk_en,
	// Sub clock tick, already synchronised
	input wire sub_tick,
	// Configuration
	input wire [1:0] src_sel,
	input wire [2:0] period_sel,
	input wire run,
	// Overflow pulse
	output reg overflow
);
`include "isb_defines.vh"

	reg [1:0] div4;
	reg [CNT_W-1:0] count;
	wire tick;
	wire [CNT_W-1:0] terminal;

	// Prescaler clock as an enable pulse, keeps one clock domain
	assign tick = (src_sel == `ISB_SRC_SYS) ? 1'b1 :
		(src_sel == `ISB_SRC_SYS4) ? (div4 == `ISB_SYS_DIV) : sub_tick;

	// Last count of a period: 2^(8+code) - 1
	assign terminal = ({{(CNT_W-1){1'b0}}, 1'b1} << (`ISB_PERIOD_BASE + period_sel))
		- {{(CNT_W-1){1'b0}}, 1'b1};

	// Divide-by-four prescaler, free running
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			div4 <= 2'h0;
		end else if (clk_en) begin
			div4 <= div4 + 2'h1;
		end
	end

	// Divider; >= guards against a period shortened mid-count
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count <= {CNT_W{1'b0}};
			overflow <= 1'b0;
		end else if (clk_en) begin
			overflow <= 1'b0;
			if (!run) begin
				count <= {CNT_W{1'b0}};
			end else if (tick) begin
				if (count >= terminal) begin
					count <= {CNT_W{1'b0}};
					overflow <= 1'b1;
				end else begin
					count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// ---- design/isb_irq_ctrl.v ----
// Interrupt request controller with two time bases
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module isb_irq_ctrl #(
	parameter CNT_W = 15
) (
	// Clock, reset, clock enable
	input wire clock,
	input wire arst_n,
	input wire clk_en,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	// Serial port conditions, same clock
	input wire ser_tx_empty,
	input wire ser_tx_idle,
	input wire ser_rx_trigger,
	input wire ser_rx_overrun,
	input wire ser_addr_detect,
	input wire ser_pin_wake,
	// Other sources, same clock pulses
	input wire eeprom_cycle_end,
	input wire conversion_end,
	input wire [1:0] timer_period_match,
	input wire [1:0] timer_second_match,
	// Asynchronous inputs
	input wire low_supply_detect,
	input wire sub_clock,
	// Program sequencer side
	input wire stack_full,
	input wire irq_ack,
	input wire return_from_irq,
	output reg irq_req,
	output reg [2:0] irq_vector,
	output reg wake_up
);
`include "isb_defines.vh"

	// Configuration registers
	reg [1:0] prescaler0_clock_select;
	reg [1:0] prescaler1_clock_select;
	reg periodic0_run;
	reg periodic1_run;
	reg [2:0] periodic0_period_sel;
	reg [2:0] periodic1_period_sel;
	reg global_irq_enable;
	reg serial_port_irq_enable;
	reg periodic0_irq_enable;
	reg periodic1_irq_enable;
	reg eeprom_done_enable;
	reg conversion_done_enable;
	reg low_supply_enable;
	reg [1:0] grouped_irq_enable;
	reg [1:0] timer_period_match_enable;
	reg [1:0] timer_second_match_enable;

	// Request flags, one per vector, bit number is the vector
	reg [7:0] irq_flags;
	reg [1:0] timer_period_match_flag;
	reg [1:0] timer_second_match_flag;
	reg [7:0] next_irq_flags;
	reg [1:0] next_tpf;
	reg [1:0] next_tsf;

	// Synchronisers and edge history
	reg [2:0] sub_sync;
	reg [2:0] lv_sync;
	reg [5:0] ser_cond_d;
	reg [3:0] tm_src_d;

	wire [5:0] ser_cond;
	wire ser_event;
	wire lv_event;
	wire sub_tick;
	wire tb0_overflow;
	wire tb1_overflow;
	wire [7:0] irq_enables;
	wire [7:0] eligible;
	wire [3:0] tm_src;
	wire [1:0] grp_event;
	wire ack_ok;
	wire [7:0] ack_clear;
	wire wr_flag;
	wire wr_tm0;
	wire wr_tm1;

	// Lowest set bit wins
	function [2:0] pick_vector;
		input [7:0] pend;
		integer i;
		begin
			pick_vector = 3'h0;
			for (i = 7; i >= 0; i = i - 1) begin
				if (pend[i]) begin
					pick_vector = i[2:0];
				end
			end
		end
	endfunction

	// Register decode for a write strobe
	function wr_hit;
		input [7:0] addr;
		input [7:0] ofs;
		input strobe;
		begin
			wr_hit = strobe && (addr == ofs);
		end
	endfunction

	// Two flops before any logic looks at the pins
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sub_sync <= 3'h0;
			lv_sync <= 3'h0;
		end else if (clk_en) begin
			sub_sync <= {sub_sync[1:0], sub_clock};
			lv_sync <= {lv_sync[1:0], low_supply_detect};
		end
	end

	assign sub_tick = sub_sync[1] & ~sub_sync[2];
	assign lv_event = lv_sync[1] & ~lv_sync[2];

	// Any new serial condition raises the request, even if another still stands
	assign ser_cond = {ser_tx_empty, ser_tx_idle, ser_rx_trigger,
		ser_rx_overrun, ser_addr_detect, ser_pin_wake};
	assign ser_event = |(ser_cond & ~ser_cond_d);

	// Enabled timer flags feed the grouped requests
	assign tm_src = {timer_second_match_flag[1] & timer_second_match_enable[1],
		timer_period_match_flag[1] & timer_period_match_enable[1],
		timer_second_match_flag[0] & timer_second_match_enable[0],
		timer_period_match_flag[0] & timer_period_match_enable[0]};
	assign grp_event = {|(tm_src[3:2] & ~tm_src_d[3:2]),
		|(tm_src[1:0] & ~tm_src_d[1:0])};

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ser_cond_d <= 6'h00;
			tm_src_d <= 4'h0;
		end else if (clk_en) begin
			ser_cond_d <= ser_cond;
			tm_src_d <= tm_src;
		end
	end

	// Time bases
	isb_timebase #(.CNT_W(CNT_W)) u_tb0 (
		.clock(clock),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.sub_tick(sub_tick),
		.src_sel(prescaler0_clock_select),
		.period_sel(periodic0_period_sel),
		.run(periodic0_run),
		.overflow(tb0_overflow)
	);

	isb_timebase #(.CNT_W(CNT_W)) u_tb1 (
		.clock(clock),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.sub_tick(sub_tick),
		.src_sel(prescaler1_clock_select),
		.period_sel(periodic1_period_sel),
		.run(periodic1_run),
		.overflow(tb1_overflow)
	);

	// Per-vector enables in vector order
	assign irq_enables = {low_supply_enable, grouped_irq_enable[1], grouped_irq_enable[0],
		conversion_done_enable, eeprom_done_enable, periodic1_irq_enable,
		periodic0_irq_enable, serial_port_irq_enable};
	assign eligible = irq_flags & irq_enables;

	// Service only counts while a request is shown
	assign ack_ok = irq_ack & irq_req;
	assign ack_clear = ack_ok ? (8'h01 << irq_vector) : 8'h00;

	assign wr_flag = wr_hit(reg_addr, `ISB_FLAG_OFS, reg_write);
	assign wr_tm0 = wr_hit(reg_addr, `ISB_TM0_OFS, reg_write);
	assign wr_tm1 = wr_hit(reg_addr, `ISB_TM1_OFS, reg_write);

	// Flag update: write, then service clear, then hardware set wins
	always @* begin
		next_irq_flags = wr_flag ? reg_wdata : irq_flags;
		next_irq_flags = next_irq_flags & ~ack_clear;
		next_irq_flags[`ISB_VEC_SER] = next_irq_flags[`ISB_VEC_SER] | ser_event;
		next_irq_flags[`ISB_VEC_TB0] = next_irq_flags[`ISB_VEC_TB0] | tb0_overflow;
		next_irq_flags[`ISB_VEC_TB1] = next_irq_flags[`ISB_VEC_TB1] | tb1_overflow;
		next_irq_flags[`ISB_VEC_EE] = next_irq_flags[`ISB_VEC_EE] | eeprom_cycle_end;
		next_irq_flags[`ISB_VEC_ADC] = next_irq_flags[`ISB_VEC_ADC] | conversion_end;
		next_irq_flags[`ISB_VEC_GRP0] = next_irq_flags[`ISB_VEC_GRP0] | grp_event[0];
		next_irq_flags[`ISB_VEC_GRP1] = next_irq_flags[`ISB_VEC_GRP1] | grp_event[1];
		next_irq_flags[`ISB_VEC_LV] = next_irq_flags[`ISB_VEC_LV] | lv_event;
		// Timer flags are cleared by software only, never by service
		next_tpf = timer_period_match_flag;
		next_tsf = timer_second_match_flag;
		if (wr_tm0) begin
			next_tpf[0] = reg_wdata[`ISB_TM_PF_BIT];
			next_tsf[0] = reg_wdata[`ISB_TM_SF_BIT];
		end
		if (wr_tm1) begin
			next_tpf[1] = reg_wdata[`ISB_TM_PF_BIT];
			next_tsf[1] = reg_wdata[`ISB_TM_SF_BIT];
		end
		next_tpf = next_tpf | timer_period_match;
		next_tsf = next_tsf | timer_second_match;
	end

	// Flags, wake pulse and request outputs
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_flags <= 8'h00;
			timer_period_match_flag <= 2'h0;
			timer_second_match_flag <= 2'h0;
			wake_up <= 1'b0;
			irq_req <= 1'b0;
			irq_vector <= 3'h0;
		end else if (clk_en) begin
			irq_flags <= next_irq_flags;
			timer_period_match_flag <= next_tpf;
			timer_second_match_flag <= next_tsf;
			// Enables play no part in waking
			wake_up <= |({next_irq_flags, next_tpf, next_tsf} &
				~{irq_flags, timer_period_match_flag, timer_second_match_flag});
			// Dropped in the service cycle so one request is never taken twice
			irq_req <= global_irq_enable & (|eligible) & ~stack_full & ~ack_ok;
			irq_vector <= pick_vector(eligible);
		end
	end

	// Software-visible configuration and global enable
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prescaler0_clock_select <= 2'h0;
			prescaler1_clock_select <= 2'h0;
			periodic0_run <= 1'b0;
			periodic1_run <= 1'b0;
			periodic0_period_sel <= 3'h0;
			periodic1_period_sel <= 3'h0;
			global_irq_enable <= 1'b0;
			serial_port_irq_enable <= 1'b0;
			periodic0_irq_enable <= 1'b0;
			periodic1_irq_enable <= 1'b0;
			eeprom_done_enable <= 1'b0;
			conversion_done_enable <= 1'b0;
			low_supply_enable <= 1'b0;
			grouped_irq_enable <= 2'h0;
			timer_period_match_enable <= 2'h0;
			timer_second_match_enable <= 2'h0;
		end else if (clk_en) begin
			if (wr_hit(reg_addr, `ISB_PSC0_OFS, reg_write)) begin
				prescaler0_clock_select <= reg_wdata[1:0];
			end
			if (wr_hit(reg_addr, `ISB_PSC1_OFS, reg_write)) begin
				prescaler1_clock_select <= reg_wdata[1:0];
			end
			if (wr_hit(reg_addr, `ISB_TIMEBASE0_CONTROL_OFS, reg_write)) begin
				periodic0_run <= reg_wdata[`ISB_TB_RUN_BIT];
				periodic0_period_sel <= reg_wdata[2:0];
			end
			if (wr_hit(reg_addr, `ISB_TIMEBASE1_CONTROL_OFS, reg_write)) begin
				periodic1_run <= reg_wdata[`ISB_TB_RUN_BIT];
				periodic1_period_sel <= reg_wdata[2:0];
			end
			if (wr_hit(reg_addr, `ISB_IEN_OFS, reg_write)) begin
				serial_port_irq_enable <= reg_wdata[1];
				periodic0_irq_enable <= reg_wdata[2];
				periodic1_irq_enable <= reg_wdata[3];
				eeprom_done_enable <= reg_wdata[4];
				conversion_done_enable <= reg_wdata[5];
				low_supply_enable <= reg_wdata[6];
			end
			if (wr_hit(reg_addr, `ISB_GEN_OFS, reg_write)) begin
				grouped_irq_enable <= reg_wdata[1:0];
			end
			if (wr_tm0) begin
				timer_period_match_enable[0] <= reg_wdata[`ISB_TM_PE_BIT];
				timer_second_match_enable[0] <= reg_wdata[`ISB_TM_SE_BIT];
			end
			if (wr_tm1) begin
				timer_period_match_enable[1] <= reg_wdata[`ISB_TM_PE_BIT];
				timer_second_match_enable[1] <= reg_wdata[`ISB_TM_SE_BIT];
			end
			// Service beats a return or a write in the same cycle
			if (ack_ok) begin
				global_irq_enable <= 1'b0;
			end else if (return_from_irq) begin
				global_irq_enable <= 1'b1;
			end else if (wr_hit(reg_addr, `ISB_IEN_OFS, reg_write)) begin
				global_irq_enable <= reg_wdata[`ISB_GIE_BIT];
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= `ISB_REG_RST;
		end else if (clk_en) begin
			reg_rdata <= `ISB_REG_RST;
			if (reg_read) begin
				case (reg_addr)
				`ISB_PSC0_OFS: begin
					reg_rdata <= {6'h00, prescaler0_clock_select};
				end
				`ISB_PSC1_OFS: begin
					reg_rdata <= {6'h00, prescaler1_clock_select};
				end
				`ISB_TIMEBASE0_CONTROL_OFS: begin
					reg_rdata <= {periodic0_run, 4'h0, periodic0_period_sel};
				end
				`ISB_TIMEBASE1_CONTROL_OFS: begin
					reg_rdata <= {periodic1_run, 4'h0, periodic1_period_sel};
				end
				`ISB_IEN_OFS: begin
					reg_rdata <= {1'b0, irq_enables[`ISB_VEC_LV], irq_enables[4:0],
						global_irq_enable};
				end
				`ISB_GEN_OFS: begin
					reg_rdata <= {6'h00, grouped_irq_enable};
				end
				`ISB_FLAG_OFS: begin
					reg_rdata <= irq_flags;
				end
				`ISB_TM0_OFS: begin
					reg_rdata <= {2'h0, timer_second_match_flag[0], timer_period_match_flag[0],
						2'h0, timer_second_match_enable[0], timer_period_match_enable[0]};
				end
				`ISB_TM1_OFS: begin
					reg_rdata <= {2'h0, timer_second_match_flag[1], timer_period_match_flag[1],
						2'h0, timer_second_match_enable[1], timer_period_match_enable[1]};
				end
				`ISB_STAT_OFS: begin
					reg_rdata <= {4'h0, irq_vector, irq_req};
				end
				default: begin
					reg_rdata <= `ISB_REG_RST;
				end
				endcase
			end
		end
	end
endmodule

// ---- verif/isb_irq_ctrl_assertions.sv ----
// Port checker for the interrupt request controller, bound to its top module
`timescale 1ns/100ps
`include "isb_defines.vh"
module isb_irq_ctrl_assertions #(
	parameter CNT_W = 15
) (
	// Clock and reset
	input wire clock,
	input wire arst_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	// Sequencer side
	input wire stack_full,
	input wire irq_ack,
	input wire return_from_irq,
	input wire irq_req,
	input wire [2:0] irq_vector
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Steps of a select write followed by its read-back, and a taken service
	sequence sel_write;
		reg_write && reg_addr == `ISB_PSC0_OFS;
	endsequence
	sequence sel_read;
		reg_read && reg_addr == `ISB_PSC0_OFS;
	endsequence
	sequence serviced;
		irq_ack && irq_req;
	endsequence

	chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	chk_unmapped_zero: assert property (reg_read && reg_addr > `ISB_STAT_OFS |=> reg_rdata == 8'h00)
		else $error("unmapped read returned data");
	chk_ctrl_reserved: assert property (
		reg_read && (reg_addr == `ISB_TIMEBASE0_CONTROL_OFS || reg_addr == `ISB_TIMEBASE1_CONTROL_OFS)
		|=> reg_rdata[6:3] == 4'h0) else $error("control reserved bits not zero");
	chk_sel_readback: assert property (
		sel_write ##2 sel_read |=> reg_rdata == {6'h00, $past(reg_wdata[1:0], 3)})
		else $error("prescaler select read-back wrong");
	chk_stack_block: assert property (stack_full && $past(stack_full) |-> !irq_req)
		else $error("request raised with stack full");
	chk_req_start: assert property ($rose(irq_req) |-> !$past(stack_full))
		else $error("request rose from a full stack");
	chk_ack_drop: assert property (serviced |-> ##[1:2] !irq_req)
		else $error("request did not drop after service");
	chk_gie_cleared: assert property (
		serviced ##1 (!return_from_irq && !reg_write) [*3] |-> !irq_req)
		else $error("request again without global enable");
endmodule

bind isb_irq_ctrl isb_irq_ctrl_assertions #(.CNT_W(CNT_W)) isb_irq_ctrl_assertions_inst (
	.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.stack_full(stack_full), .irq_ack(irq_ack), .return_from_irq(return_from_irq),
	.irq_req(irq_req), .irq_vector(irq_vector));

// ---- verif/isb_cpu_model.sv ----
// Program sequencer stand-in that takes vectors and returns from them
`timescale 1ns/100ps
module isb_cpu_model (
	// Clock and reset
	input wire clock,
	input wire arst_n,
	// Bench control: return with or without re-enable
	input wire return_from_irq_en,
	// Controller side
	input wire irq_req,
	input wire [2:0] irq_vector,
	output reg irq_ack,
	output reg return_from_irq,
	// Service record
	output reg [2:0] served_vec,
	output reg [15:0] served_cnt
);
	reg [1:0] wait_cnt;
	reg [2:0] ret_cnt;

	// Ack two cycles into a request; the count restarts after an ack so that
	// the lagging request is never taken twice
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_ack <= 1'b0;
			return_from_irq <= 1'b0;
			served_vec <= 3'h0;
			served_cnt <= 16'h0000;
			wait_cnt <= 2'h0;
			ret_cnt <= 3'h0;
		end else begin
			irq_ack <= irq_req && !irq_ack && wait_cnt == 2'h1;
			wait_cnt <= (irq_req && !irq_ack) ? wait_cnt + 2'h1 : 2'h0;
			return_from_irq <= ret_cnt == 3'h1 && return_from_irq_en;
			if (ret_cnt != 3'h0)
				ret_cnt <= ret_cnt - 3'h1;
			// Vector recorded at the edge the controller takes the ack
			if (irq_ack && irq_req) begin
				served_vec <= irq_vector;
				served_cnt <= served_cnt + 16'h0001;
				ret_cnt <= 3'h5;
			end
		end
	end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the interrupt request controller
`timescale 1ns/100ps
`include "isb_defines.vh"
module testbench;
	// Stimulus
	reg clock = 1'b0;
	reg arst_n = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_write = 1'b0;
	reg reg_read = 1'b0;
	reg [11:0] src = 12'h000;
	reg low_supply_detect = 1'b0;
	reg sub_clock = 1'b0;
	reg stack_full = 1'b0;
	reg return_from_irq_en = 1'b0;
	reg clk_en = 1'b1;
	// Observed
	wire [7:0] reg_rdata;
	wire irq_req, irq_ack, return_from_irq, wake_up;
	wire [2:0] irq_vector, served_vec;
	wire [15:0] served_cnt;
	// Bookkeeping
	integer fails = 0;
	integer comparisons = 0;
	integer cyc = 0;
	integer wakes = 0;
	integer i, t;

	always #25 clock = ~clock;
	// Sub clock at an eighth of the rate, never on a system edge
	initial #13 forever #200 sub_clock = ~sub_clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (wake_up === 1'b1)
			wakes <= wakes + 1;
	end

	isb_irq_ctrl isb_irq_ctrl_inst (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .ser_tx_empty(src[0]),
		.ser_tx_idle(src[1]), .ser_rx_trigger(src[2]), .ser_rx_overrun(src[3]),
		.ser_addr_detect(src[4]), .ser_pin_wake(src[5]), .eeprom_cycle_end(src[6]),
		.conversion_end(src[7]), .timer_period_match(src[9:8]),
		.timer_second_match(src[11:10]), .low_supply_detect(low_supply_detect),
		.sub_clock(sub_clock), .stack_full(stack_full), .irq_ack(irq_ack),
		.return_from_irq(return_from_irq), .irq_req(irq_req), .irq_vector(irq_vector),
		.wake_up(wake_up));
	isb_cpu_model isb_cpu_model_inst (.clock(clock), .arst_n(arst_n), .return_from_irq_en(return_from_irq_en),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
		.return_from_irq(return_from_irq), .served_vec(served_vec), .served_cnt(served_cnt));

	task chk(input [15:0] got, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_wdata <= d;
			reg_write <= 1'b1;
			@(posedge clock);
			reg_write <= 1'b0;
		end
	endtask
	// Data stands only in the cycle after the strobe
	task rd(input [7:0] a, input [7:0] e);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_read <= 1'b1;
			@(posedge clock);
			reg_read <= 1'b0;
			#1 chk(reg_rdata, e);
		end
	endtask
	task pulse(input integer b);
		begin
			@(posedge clock);
			src[b] <= 1'b1;
			@(posedge clock);
			src[b] <= 1'b0;
		end
	endtask
	// Bounded wait for the next service, then its vector
	task serve(input [2:0] v);
		integer n, k;
		begin
			n = served_cnt;
			k = 0;
			while (served_cnt == n && k < 6000) begin
				@(posedge clock);
				#1 k = k + 1;
			end
			chk({k < 6000, served_vec}, {1'b1, v});
		end
	endtask
	// Two overflows of one time base, their spacing in cycles
	task tb_run(input n, input [1:0] s, input [2:0] p, input [15:0] len);
		integer t0;
		begin
			wr({7'h00, n}, {6'h00, s});
			wr(8'h02 + n, {5'h10, p});
			serve(3'h1 + n);
			t0 = cyc;
			serve(3'h1 + n);
			chk(cyc - t0, len);
			wr(8'h02 + n, 8'h00);
		end
	endtask
	task stop_test;
		begin
			$display("comparisons %0d fails %0d", comparisons, fails);
			if (fails == 0 && comparisons > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	initial begin
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		// Reset state, one unmapped place included
		for (i = 0; i < 11; i = i + 1)
			rd(i[7:0], 8'h00);
		wr(8'h0a, 8'hff);
		rd(8'h0a, 8'h00);
		wr(`ISB_PSC0_OFS, 8'hff);
		rd(`ISB_PSC0_OFS, 8'h03);
		wr(`ISB_TIMEBASE1_CONTROL_OFS, 8'hff);
		rd(`ISB_TIMEBASE1_CONTROL_OFS, 8'h87);
		wr(`ISB_TIMEBASE1_CONTROL_OFS, 8'h00);
		// Every serial condition on its own
		return_from_irq_en <= 1'b1;
		wr(`ISB_IEN_OFS, 8'h33);
		for (i = 0; i < 6; i = i + 1) begin
			pulse(i);
			serve(`ISB_VEC_SER);
			rd(`ISB_FLAG_OFS, 8'h00);
		end
		// A full stack holds the call back
		stack_full <= 1'b1;
		pulse(6);
		repeat (20) @(posedge clock);
		#1 chk(irq_req, 1'b0);
		// Held call still names the pending source
		rd(`ISB_STAT_OFS, 8'h06);
		stack_full <= 1'b0;
		serve(`ISB_VEC_EE);
		repeat (10) @(posedge clock);
		// Plain return leaves the global enable clear
		return_from_irq_en <= 1'b0;
		pulse(7);
		serve(`ISB_VEC_ADC);
		repeat (10) @(posedge clock);
		rd(`ISB_IEN_OFS, 8'h32);
		// Flags wake and latch with enables off, then go by priority
		wr(`ISB_IEN_OFS, 8'h00);
		t = wakes;
		pulse(7);
		pulse(6);
		repeat (3) @(posedge clock);
		chk(wakes - t, 16'h0002);
		rd(`ISB_FLAG_OFS, 8'h18);
		return_from_irq_en <= 1'b1;
		wr(`ISB_IEN_OFS, 8'h33);
		serve(`ISB_VEC_EE);
		serve(`ISB_VEC_ADC);
		// Grouped requests leave the timer flags set
		wr(`ISB_TM0_OFS, 8'h01);
		wr(`ISB_TM1_OFS, 8'h02);
		wr(`ISB_GEN_OFS, 8'h03);
		wr(`ISB_IEN_OFS, 8'h01);
		pulse(8);
		serve(`ISB_VEC_GRP0);
		pulse(11);
		serve(`ISB_VEC_GRP1);
		rd(`ISB_TM0_OFS, 8'h11);
		rd(`ISB_TM1_OFS, 8'h22);
		rd(`ISB_FLAG_OFS, 8'h00);
		pulse(9);
		rd(`ISB_TM1_OFS, 8'h32);
		rd(`ISB_FLAG_OFS, 8'h00);
		wr(`ISB_TM0_OFS, 8'h01);
		wr(`ISB_TM1_OFS, 8'h02);
		// Low supply
		low_supply_detect <= 1'b1;
		wr(`ISB_IEN_OFS, 8'h41);
		serve(`ISB_VEC_LV);
		// Time base periods over all three clock sources
		wr(`ISB_IEN_OFS, 8'h0d);
		tb_run(1'b0, 2'h0, 3'h0, 16'h0100);
		tb_run(1'b1, 2'h1, 3'h0, 16'h0400);
		tb_run(1'b0, 2'h2, 3'h1, 16'h1000);
		// A stopped time base stays quiet, even with a period programmed
		wr(`ISB_TIMEBASE0_CONTROL_OFS, 8'h07);
		t = served_cnt;
		repeat (600) @(posedge clock);
		#1 chk(served_cnt, t[15:0]);
		// Clock enable low: writes and source pulses are not taken
		clk_en <= 1'b0;
		wr(`ISB_GEN_OFS, 8'h00);
		pulse(7);
		clk_en <= 1'b1;
		rd(`ISB_GEN_OFS, 8'h03);
		rd(`ISB_FLAG_OFS, 8'h00);
		stop_test;
	end

	// Watchdog
	initial begin
		#(50 * 40000);
		fails = fails + 1;
		stop_test;
	end
endmodule
